//--- design/csc_top.sv
// Capacitive sense control with an AXI4-Lite register slave
// Assumes the analog oscillator direction arrives asynchronously and Timer0 clock lines are sampled here
`timescale 1ns/10ps
`include "csc_defines.svh"

module csc_top #(
	parameter bit SMALL_VARIANT = 1'b0
)
(
	input  wire logic                 clk,
	input  wire logic                 arst_n,
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic                 sense_osc_out,
	input  wire logic                 tmr_ext_clock_pin,
	output csc_pkg::csc_analog_t      analog_sel,
	output logic                      tmr_ext_clock
);
	import csc_pkg::*;

	logic              rst_meta_ff;
	logic              rst_sync_ff;
	logic              rst_n;
	logic [1:0]        osc_sync_ff;
	logic [1:0]        pin_sync_ff;
	csc_ctrl_t         ctrl_ff;
	logic              tmr_clock_source_select_ff;
	csc_wr_state_t     wr_state_ff;
	logic              aw_held_ff;
	logic [7:0]        aw_addr_ff;
	logic              w_held_ff;
	logic [31:0]       w_data_ff;
	logic [3:0]        w_strb_ff;
	logic [1:0]        bresp_ff;
	logic              rvalid_ff;
	logic [31:0]       rdata_ff;
	logic [1:0]        rresp_ff;
	logic [15:0]       onehot;
	csc_analog_t       nxt_analog;
	csc_analog_t       analog_ff;
	logic              tmr_clk_ff;

	// Reset release through two flip-flops
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end
	assign rst_n = rst_sync_ff;

	// Pin inputs pass two flip-flops; only stage one feeds stage two
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			osc_sync_ff <= 2'h0;
			pin_sync_ff <= 2'h0;
		end
		else
		begin
			osc_sync_ff <= {osc_sync_ff[0], sense_osc_out};
			pin_sync_ff <= {pin_sync_ff[0], tmr_ext_clock_pin};
		end
	end

	// Channel mask for the fitted variant
	function automatic logic [3:0] chan_mask(input logic [3:0] code);
		chan_mask = code & (SMALL_VARIANT ? `CSC_SMALL_CH_MASK : `CSC_FULL_CH_MASK);
	endfunction

	// Write path: address and data in either order, response after both
	wire         do_write  = aw_held_ff && w_held_ff && (wr_state_ff == CSC_WR_IDLE);
	wire         wr_ctrl   = (aw_addr_ff == `CSC_OFF_CONTROL);
	wire         wr_chan   = (aw_addr_ff == `CSC_OFF_CHANNEL);
	wire         wr_tmr    = (aw_addr_ff == `CSC_OFF_TMR_CFG);
	wire         wr_hit    = wr_ctrl || wr_chan || wr_tmr;
	wire         lane0     = w_strb_ff[0];
	assign s_axi_awready = !aw_held_ff;
	assign s_axi_wready  = !w_held_ff;
	assign s_axi_bvalid  = (wr_state_ff == CSC_WR_RESP);
	assign s_axi_bresp   = bresp_ff;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_held_ff  <= 1'b0;
			aw_addr_ff  <= 8'h00;
			w_held_ff   <= 1'b0;
			w_data_ff   <= 32'h0000_0000;
			w_strb_ff   <= 4'h0;
			wr_state_ff <= CSC_WR_IDLE;
			bresp_ff    <= `CSC_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && !aw_held_ff)
			begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && !w_held_ff)
			begin
				w_held_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			case (wr_state_ff)
				CSC_WR_IDLE:
				begin
					if (do_write)
					begin
						wr_state_ff <= CSC_WR_RESP;
						bresp_ff    <= wr_hit ? `CSC_RESP_OKAY : `CSC_RESP_SLVERR;
					end
				end
				CSC_WR_RESP:
				begin
					if (s_axi_bready)
					begin
						wr_state_ff <= CSC_WR_IDLE;
						aw_held_ff  <= 1'b0;
						w_held_ff   <= 1'b0;
					end
				end
				default:
				begin
					wr_state_ff <= CSC_WR_IDLE;
				end
			endcase
		end
	end

	// Control registers; direction bit is never written
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_ff                    <= '0;
			tmr_clock_source_select_ff <= `CSC_RST_TMR_CS;
		end
		else if (do_write && lane0)
		begin
			if (wr_ctrl)
			begin
				ctrl_ff.sense_module_enable   <= w_data_ff[`CSC_BIT_ENABLE];
				ctrl_ff.sense_current_range   <= w_data_ff[`CSC_BIT_RANGE_HI:`CSC_BIT_RANGE_LO];
				ctrl_ff.tmr_ext_source_select <= w_data_ff[`CSC_BIT_EXT_SEL];
			end
			if (wr_chan)
			begin
				ctrl_ff.sense_channel_select <= chan_mask(w_data_ff[3:0]);
			end
			if (wr_tmr)
			begin
				tmr_clock_source_select_ff <= w_data_ff[`CSC_BIT_TMR_CS];
			end
		end
	end

	// Read data assembly
	wire [7:0] rd_ctrl = {ctrl_ff.sense_module_enable, 3'h0, ctrl_ff.sense_current_range,
		osc_sync_ff[1], ctrl_ff.tmr_ext_source_select};
	wire [7:0] rd_chan = {4'h0, chan_mask(ctrl_ff.sense_channel_select)};
	wire [7:0] rd_tmr  = {7'h00, tmr_clock_source_select_ff};
	wire [7:0] rd_word     = {s_axi_araddr[7:2], 2'b00}; // Word aligned, same width as the offsets
	wire       rd_sel_ctrl = (rd_word == `CSC_OFF_CONTROL);
	wire       rd_sel_chan = (rd_word == `CSC_OFF_CHANNEL);
	wire       rd_sel_tmr  = (rd_word == `CSC_OFF_TMR_CFG);
	wire       rd_hit      = rd_sel_ctrl || rd_sel_chan || rd_sel_tmr;
	wire [7:0] rd_byte     = rd_sel_ctrl ? rd_ctrl : rd_sel_chan ? rd_chan : rd_sel_tmr ? rd_tmr : 8'h00;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	// Read path, one outstanding
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= `CSC_RESP_OKAY;
		end
		else if (s_axi_arvalid && !rvalid_ff)
		begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= {24'h00_0000, rd_byte};
			rresp_ff  <= rd_hit ? `CSC_RESP_OKAY : `CSC_RESP_SLVERR;
		end
		else if (rvalid_ff && s_axi_rready)
		begin
			rvalid_ff <= 1'b0;
		end
	end

	csc_channel_decode u_decode
	(
		.enable         (ctrl_ff.sense_module_enable),
		.channel_code   (chan_mask(ctrl_ff.sense_channel_select)),
		.channel_onehot (onehot)
	);

	// Analog selection and Timer0 external clock source
	assign nxt_analog.connect        = ctrl_ff.sense_module_enable;
	assign nxt_analog.channel_onehot = onehot;
	assign nxt_analog.current_range  = ctrl_ff.sense_current_range;
	wire   nxt_tmr_clk = ctrl_ff.tmr_ext_source_select ? osc_sync_ff[1] : pin_sync_ff[1];

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			analog_ff  <= '0;
			tmr_clk_ff <= 1'b0;
		end
		else
		begin
			analog_ff  <= nxt_analog;
			tmr_clk_ff <= tmr_clock_source_select_ff ? nxt_tmr_clk : 1'b0;
		end
	end
	assign analog_sel    = analog_ff;
	assign tmr_ext_clock = tmr_clk_ff;

endmodule

//--- design/csc_defines.svh
// Offsets, field positions, reset values and codes of the capacitive sense control block
// Assumes inclusion by bare name from any design file
`ifndef CSC_DEFINES_SVH
`define CSC_DEFINES_SVH

`define CSC_OFF_CONTROL     8'h00
`define CSC_OFF_CHANNEL     8'h04
`define CSC_OFF_TMR_CFG     8'h08

`define CSC_BIT_ENABLE      7
`define CSC_BIT_RANGE_HI    3
`define CSC_BIT_RANGE_LO    2
`define CSC_BIT_DIRECTION   1
`define CSC_BIT_EXT_SEL     0
`define CSC_BIT_TMR_CS      0

`define CSC_RST_CONTROL     8'h00
`define CSC_RST_CHANNEL     4'h0
`define CSC_RST_TMR_CS      1'b1

`define CSC_SMALL_CH_MASK   4'h7
`define CSC_FULL_CH_MASK    4'hF
`define CSC_RESP_OKAY       2'h0
`define CSC_RESP_SLVERR     2'h2

`endif

//--- design/csc_pkg.sv
// Types shared by the capacitive sense control block
// Assumes csc_defines.svh is on the include path
package csc_pkg;

	// Software control fields
	typedef struct packed {
		logic       sense_module_enable;
		logic [1:0] sense_current_range;
		logic       tmr_ext_source_select;
		logic [3:0] sense_channel_select;
	} csc_ctrl_t;

	// Selection handed to the analog front end
	typedef struct packed {
		logic        connect;
		logic [15:0] channel_onehot;
		logic [1:0]  current_range;
	} csc_analog_t;

	// Bus slave channel states
	typedef enum logic [1:0] {
		CSC_WR_IDLE = 2'b00,
		CSC_WR_RESP = 2'b01
	} csc_wr_state_t;

endpackage

//--- design/csc_channel_decode.sv
// Channel decoder of the capacitive sense control block
// Assumes a masked 4-bit channel code and an enable from the same clock domain
`timescale 1ns/10ps

module csc_channel_decode
(
	input  wire logic        enable,
	input  wire logic [3:0]  channel_code,
	output logic      [15:0] channel_onehot
);

	// One line per channel, none while disabled
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++)
		begin : g_ch
			assign channel_onehot[gi] = enable && (channel_code == 4'(gi));
		end
	endgenerate

endmodule

//--- testbench/csc_props.sv
// Port checker for csc_top
// Assumes it is bound to every csc_top instance
`timescale 1ns/10ps
module csc_props
	import csc_pkg::*;
#(
	parameter bit SMALL_VARIANT = 1'b0
)
(
	input wire logic                 clk,
	input wire logic                 arst_n,
	input wire logic                 s_axi_awvalid,
	input wire logic                 s_axi_awready,
	input wire logic                 s_axi_wvalid,
	input wire logic                 s_axi_wready,
	input wire logic                 s_axi_bvalid,
	input wire logic [7:0]           s_axi_araddr,
	input wire logic                 s_axi_arvalid,
	input wire logic                 s_axi_arready,
	input wire logic                 s_axi_rvalid,
	input wire logic [31:0]          s_axi_rdata,
	input wire logic                 sense_osc_out,
	input wire csc_pkg::csc_analog_t analog_sel
);
	logic [7:0] rd_addr_ff;
	logic [2:0] calm_ff;
	logic       osc_ff;
	// Taken read address, and cycles since the oscillator line last moved
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			rd_addr_ff <= 8'h00;
			calm_ff <= 3'h0;
			osc_ff <= 1'b0;
		end
		else
		begin
			if (s_axi_arvalid && s_axi_arready)
				rd_addr_ff <= s_axi_araddr;
			calm_ff <= (sense_osc_out != osc_ff) ? 3'h0 : calm_ff + {2'h0, calm_ff != 3'h7};
			osc_ff <= sense_osc_out;
		end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	a_idle_none: assert property (!analog_sel.connect |-> analog_sel.channel_onehot == 16'h0000)
		else $error("channel connected while disabled");
	a_one_chan: assert property (analog_sel.connect |-> $onehot(analog_sel.channel_onehot))
		else $error("not exactly one channel");
	a_small_chan: assert property (SMALL_VARIANT |-> analog_sel.channel_onehot[15:8] == 8'h00)
		else $error("absent channel selected");
	a_small_msb: assert property ($rose(s_axi_rvalid) && SMALL_VARIANT && rd_addr_ff == 8'h04 |-> !s_axi_rdata[3])
		else $error("absent channel bit reads 1");
	a_dir_src: assert property ($rose(s_axi_rvalid) && rd_addr_ff == 8'h00 && calm_ff > 3'h5 && osc_ff |-> s_axi_rdata[1])
		else $error("sourcing not read as 1");
	a_dir_sink: assert property ($rose(s_axi_rvalid) && rd_addr_ff == 8'h00 && calm_ff > 3'h5 && !osc_ff |-> !s_axi_rdata[1])
		else $error("sinking not read as 0");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
endmodule
bind csc_top csc_props #(.SMALL_VARIANT(SMALL_VARIANT)) u_props (.*);

//--- testbench/csc_osc_model.sv
// Behavioural sensing oscillator facing csc_top
// Assumes the core clock and the channel selection of csc_top
`timescale 1ns/10ps
module csc_osc_model
	import csc_pkg::*;
#(
	parameter int HALF = 20
)
(
	input wire logic                 clk,
	input wire csc_pkg::csc_analog_t analog_sel,
	output logic                     sense_osc_out
);
	int cnt = 0;
	// Swings only while a channel is connected, else stands still
	initial
		sense_osc_out = 1'b0;
	always @(posedge clk)
		if (analog_sel.connect)
		begin
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF - 1)
				sense_osc_out <= !sense_osc_out;
		end
endmodule

//--- testbench/tb_capacitive_sense_control.sv
// Self-checking bench for csc_top, full and small variant side by side
// Assumes csc_osc_model drives the oscillator line
`timescale 1ns/10ps
module tb_capacitive_sense_control;
	import csc_pkg::*;
	logic        clk = 1'b0, arst_n = 1'b0, tmr_ext_clock_pin = 1'b0, sense_osc_out;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdata_s, rd_d, rd_s;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tmr_ext_clock;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	csc_analog_t analog_sel, sel_s;
	int          num_errors = 0, comparisons = 0;
	// Enable, channel code, expected one-hot
	localparam logic [20:0] ROWS [6] = '{{1'b0, 4'h5, 16'h0000}, {1'b1, 4'h0, 16'h0001}, {1'b1, 4'h1, 16'h0002},
		{1'b1, 4'h7, 16'h0080}, {1'b1, 4'h8, 16'h0100}, {1'b1, 4'hF, 16'h8000}};
	always #10 clk = !clk;
	csc_top dut_u (.*);
	csc_top #(.SMALL_VARIANT(1'b1)) dut_small (.*, .s_axi_awready(), .s_axi_wready(), .s_axi_bresp(),
		.s_axi_bvalid(), .s_axi_arready(), .s_axi_rdata(rdata_s), .s_axi_rresp(), .s_axi_rvalid(),
		.analog_sel(sel_s), .tmr_ext_clock());
	csc_osc_model osc_u (.clk(clk), .analog_sel(analog_sel), .sense_osc_out(sense_osc_out));
	task automatic print_verdict();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tmo(input int n);
		if (n >= 50)
		begin
			num_errors++;
			print_verdict();
		end
	endtask
	// Write one register, both channels offered together
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rsp);
		int n;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		s_axi_bready <= 1'b0;
		tmo(n);
		check("bresp", s_axi_bresp, rsp);
	endtask
	// Read one register from both variants at once
	task automatic rd(input logic [7:0] a, input logic [1:0] rsp);
		int n;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		s_axi_rready <= 1'b0;
		rd_d = s_axi_rdata;
		rd_s = rdata_s;
		tmo(n);
		check("rresp", s_axi_rresp, rsp);
	endtask
	// Wait for an oscillator swing, then let it settle
	task automatic wait_osc();
		int n;
		logic v;
		v = sense_osc_out;
		for (n = 0; n < 50 && sense_osc_out === v; n++)
			@(posedge clk);
		tmo(n);
		repeat (6) @(posedge clk);
	endtask
	// Main sequence
	initial
	begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(8'h08, 2'h0);
		check("tmr cfg reset", rd_d, 32'h1);
		foreach (ROWS[k])
		begin
			wr(8'h04, {4'h0, ROWS[k][19:16]}, 2'h0);
			wr(8'h00, {ROWS[k][20], 7'h0C}, 2'h0);
			repeat (2) @(posedge clk);
			check("onehot", analog_sel.channel_onehot, ROWS[k][15:0]);
			check("range", analog_sel.current_range, 2'h3);
			check("small onehot", sel_s.channel_onehot, ROWS[k][20] ? 16'h1 << ROWS[k][18:16] : 16'h0);
			rd(8'h04, 2'h0);
			check("channel", rd_d, ROWS[k][19:16]);
			check("small channel", rd_s, ROWS[k][18:16]);
		end
		wr(8'h00, 8'h8E, 2'h0);
		repeat (2)
		begin
			wait_osc();
			rd(8'h00, 2'h0);
			check("direction", rd_d[1], sense_osc_out);
		end
		for (int k = 0; k < 4; k++)
		begin
			wr(8'h08, {7'h00, k != 3}, 2'h0);
			wr(8'h00, {7'h40, k == 0}, 2'h0);
			tmr_ext_clock_pin <= k[0];
			wait_osc();
			check("tmr clock", tmr_ext_clock, k == 0 ? sense_osc_out : (k == 3 ? 1'b0 : k[0]));
		end
		check("range low", analog_sel.current_range, 2'h0);
		wr(8'h0C, 8'hFF, 2'h2);
		rd(8'h0C, 2'h2);
		check("unmapped", rd_d, 32'h0);
		// Lane 0 strobe low: write answered but channel left alone
		s_axi_wstrb <= 4'hE;
		wr(8'h04, 8'h03, 2'h0);
		s_axi_wstrb <= 4'hF;
		rd(8'h04, 2'h0);
		check("strobe off", rd_d, 32'hF);
		check("small strobe off", rd_s, 32'h7);
		arst_n <= 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		check("sel after reset", analog_sel, 18'h0);
		check("bus after reset", {s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid}, 5'h1C);
		check("tmr after reset", tmr_ext_clock, 1'b0);
		rd(8'h04, 2'h0);
		check("channel after reset", rd_d, 32'h0);
		print_verdict();
	end
endmodule
